// [src/efi_pkg.sv]
package efi_pkg;

  localparam logic [2:0] PAGE_CTRL     = 3'h1;
  localparam logic [2:0] PAGE_STAT     = 3'h4;
  localparam logic [4:0] ADDR_VECTOR   = 5'h12;
  localparam logic [4:0] ADDR_CTRL     = 5'h1A;
  localparam logic [4:0] ADDR_MASK0    = 5'h1B;
  localparam logic [4:0] ADDR_MASK1    = 5'h1C;
  localparam logic [4:0] ADDR_MASK2    = 5'h1D;
  localparam logic [4:0] ADDR_MASK3    = 5'h1E;

  localparam int CTRL_SUSPEND_BIT = 6;
  localparam int CTRL_ACK_BIT     = 5;

  localparam logic [7:0] MASK0_RESET = 8'h00;
  localparam logic [7:0] MASK1_RESET = 8'hFF;
  localparam logic [7:0] MASK2_RESET = 8'hFF;
  localparam logic [7:0] MASK3_RESET = 8'hFF;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  localparam int VEC_SYNC     = 7;
  localparam int VEC_ALARM    = 6;
  localparam int VEC_COUNT    = 5;
  localparam int VEC_OVERFLOW = 4;
  localparam int VEC_SECOND   = 3;
  localparam int VEC_SLIP     = 2;
  localparam int VEC_MAINT    = 1;
  localparam int VEC_SIGNAL   = 0;

  typedef enum logic [1:0] {
    EFI_PORT_PROCESSOR,
    EFI_PORT_CONTROLLER,
    EFI_PORT_STREAM
  } efi_port_mode_e;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] page;
    logic [4:0] addr;
    logic [7:0] wdata;
  } efi_bus_s;

  typedef struct packed {
    logic [7:0] mask3;
    logic [7:0] mask2;
    logic [7:0] mask1;
    logic [7:0] mask0;
  } efi_events_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] mask3;
    logic [7:0] vector;
    logic [7:0] rdata;
  } efi_state_s;

endpackage : efi_pkg

// [src/efi_interrupt_unit.sv]
`timescale 1ns/1ps
// How it works
// - Processor or controller port read of the vector clears it and releases request.
// - Toggling the acknowledge bit clears pending interrupts in every port mode.
// - Each event has its own mask bit in four mask words.
// - Reset masks words one to three and unmasks word zero.
// - Word zero: sync loss, remote alarm, AIS, TS16 ones, LOS, FAS error, BPV ovf, slip.
// - Word one: E-bit, CRC-4, consecutive FAS, BPV, RAI/CRC, bit error, bit 0 signalling.
// - Word two: E-bit ovf, CRC ovf, CRC align, FAS ovf, RAI ovf, BER ovf, aux; bit 0 free.
// - Word three: MF loss, CRC sync loss, remote CRC fail, remote MF, second, stop, start, match.
// - Suspend withholds new events but not pending ones, and leaves the masks untouched.
// - Vector reads as eight category bits at page four, address 12H.
// - Unmasked event pulls request low and sets category bits.
// - Vector bits seven to zero: sync, alarm, count, overflow, second, slip, maint, signal.
module efi_interrupt_unit (
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    soft_reset_i,
  input  wire efi_pkg::efi_port_mode_e port_mode_i,
  input  wire efi_pkg::efi_bus_s       bus_i,
  input  wire efi_pkg::efi_events_s    events_i,
  output logic [7:0]                   rdata_o,
  output logic [7:0]                   vector_bits_o,
  output logic                         irq_o,
  output logic                         irq_oe_n_o
);
  import efi_pkg::*;

  efi_state_s  state_reg;
  efi_state_s  state_next;

  logic        suspended;
  logic [7:0]  live_word0;
  logic [7:0]  live_word1;
  logic [7:0]  live_word2;
  logic [7:0]  live_word3;

  logic        cat_sync;
  logic        cat_alarm;
  logic        cat_count;
  logic        cat_overflow;
  logic        cat_second;
  logic        cat_slip;
  logic        cat_maint;
  logic        cat_signal;
  logic [7:0]  cat;

  // Decoded strobes of the register bus.
  logic        sel_vector;
  logic        sel_ctrl_page;
  logic        sel_ctrl_word;
  logic        rd_en_vector;
  logic        rd_en_ctrl_page;
  logic        read_clears;
  logic        vec_read;
  logic        ack_differs;
  logic        ack_toggle;
  logic        clear_now;

  logic        wr_en_ctrl;
  logic        wr_en_mask0;
  logic        wr_en_mask1;
  logic        wr_en_mask2;
  logic        wr_en_mask3;

  logic        pending;

  // Suspend only gates the events, so the mask words keep what the host wrote.
  assign suspended = state_reg.ctrl[CTRL_SUSPEND_BIT];

  // One gate per mask word, so every source is masked and suspended the same way.
  efi_mask_gate i_gate_word0 (
    .events_i  (events_i.mask0),
    .mask_i    (state_reg.mask0),
    .suspend_i (suspended),
    .live_o    (live_word0)
  );

  efi_mask_gate i_gate_word1 (
    .events_i  (events_i.mask1),
    .mask_i    (state_reg.mask1),
    .suspend_i (suspended),
    .live_o    (live_word1)
  );

  efi_mask_gate i_gate_word2 (
    .events_i  (events_i.mask2),
    .mask_i    (state_reg.mask2),
    .suspend_i (suspended),
    .live_o    (live_word2)
  );

  efi_mask_gate i_gate_word3 (
    .events_i  (events_i.mask3),
    .mask_i    (state_reg.mask3),
    .suspend_i (suspended),
    .live_o    (live_word3)
  );

  // Category grouping of each source into its vector bit.
  assign cat_sync     = live_word0[7] | (|live_word3[7:4]);
  assign cat_alarm    = (|live_word0[6:3]) | live_word2[1];
  assign cat_count    = live_word0[2] | (|live_word1[7:2]);
  assign cat_overflow = live_word0[1] | live_word2[7] | live_word2[6]
                        | (|live_word2[4:2]);
  assign cat_second   = live_word3[3] | live_word2[5];
  assign cat_slip     = live_word0[0];
  assign cat_maint    = |live_word3[2:0];
  assign cat_signal   = live_word1[0];
  // The order follows the vector bit positions, sync at the top, signalling at the bottom.
  assign cat = {cat_sync, cat_alarm, cat_count, cat_overflow,
                cat_second, cat_slip, cat_maint, cat_signal};

  assign sel_vector      = bus_i.page == PAGE_STAT && bus_i.addr == ADDR_VECTOR;
  assign sel_ctrl_page   = bus_i.page == PAGE_CTRL;
  assign sel_ctrl_word   = sel_ctrl_page && bus_i.addr == ADDR_CTRL;
  assign rd_en_vector    = bus_i.rd && sel_vector;
  assign rd_en_ctrl_page = bus_i.rd && sel_ctrl_page;

  // The serial stream gives the host no read strobe to trust, so only a toggle clears there.
  assign read_clears = port_mode_i != EFI_PORT_STREAM;
  assign vec_read    = rd_en_vector && read_clears;
  // Only a change of the acknowledge bit clears; rewriting the same value leaves the vector.
  assign ack_differs = bus_i.wdata[CTRL_ACK_BIT] != state_reg.ctrl[CTRL_ACK_BIT];
  assign ack_toggle  = bus_i.wr && sel_ctrl_word && ack_differs;
  assign clear_now   = vec_read || ack_toggle;

  // Register writes land on page one only; other pages and addresses are ignored.
  assign wr_en_ctrl  = bus_i.wr && sel_ctrl_word;
  assign wr_en_mask0 = bus_i.wr && sel_ctrl_page && bus_i.addr == ADDR_MASK0;
  assign wr_en_mask1 = bus_i.wr && sel_ctrl_page && bus_i.addr == ADDR_MASK1;
  assign wr_en_mask2 = bus_i.wr && sel_ctrl_page && bus_i.addr == ADDR_MASK2;
  assign wr_en_mask3 = bus_i.wr && sel_ctrl_page && bus_i.addr == ADDR_MASK3;

  always_comb begin
    state_next       = state_reg;
    state_next.rdata = BYTE_ZERO;
    if (rd_en_vector) begin
      state_next.rdata = state_reg.vector;
    end else if (rd_en_ctrl_page) begin
      case (bus_i.addr)
        ADDR_CTRL:  state_next.rdata = state_reg.ctrl;
        ADDR_MASK0: state_next.rdata = state_reg.mask0;
        ADDR_MASK1: state_next.rdata = state_reg.mask1;
        ADDR_MASK2: state_next.rdata = state_reg.mask2;
        ADDR_MASK3: state_next.rdata = state_reg.mask3;
        default:    state_next.rdata = BYTE_ZERO;
      endcase
    end

    // Each register has its own enable, so no write can reach two words.
    if (wr_en_ctrl) begin
      state_next.ctrl = bus_i.wdata;
    end
    if (wr_en_mask0) begin
      state_next.mask0 = bus_i.wdata;
    end
    if (wr_en_mask1) begin
      state_next.mask1 = bus_i.wdata;
    end
    if (wr_en_mask2) begin
      state_next.mask2 = bus_i.wdata;
    end
    if (wr_en_mask3) begin
      state_next.mask3 = bus_i.wdata;
    end

    // A new event in the clearing cycle survives, so no event is lost to the clear.
    if (clear_now) begin
      state_next.vector = cat;
    end else begin
      state_next.vector = state_reg.vector | cat;
    end
    // Soft reset comes last, so it wins over a write in the same cycle.
    if (soft_reset_i) begin
      state_next.mask0  = MASK0_RESET;
      state_next.mask1  = MASK1_RESET;
      state_next.mask2  = MASK2_RESET;
      state_next.mask3  = MASK3_RESET;
      state_next.ctrl   = CTRL_RESET;
      state_next.vector = BYTE_ZERO;
    end
  end

  // Only constants in the reset branch; the soft reset takes the synchronous path.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg.ctrl   <= CTRL_RESET;
      state_reg.mask0  <= MASK0_RESET;
      state_reg.mask1  <= MASK1_RESET;
      state_reg.mask2  <= MASK2_RESET;
      state_reg.mask3  <= MASK3_RESET;
      state_reg.vector <= BYTE_ZERO;
      state_reg.rdata  <= BYTE_ZERO;
    end else begin
      state_reg <= state_next;
    end
  end

  // The pin is open drain: it only ever drives low, enable low means driving.
  assign rdata_o       = state_reg.rdata;
  assign vector_bits_o = state_reg.vector;
  assign irq_o         = 1'b0;
  // The request stays low while any category bit is pending, suspended or not.
  assign pending       = |state_reg.vector;
  assign irq_oe_n_o    = ~pending;

endmodule : efi_interrupt_unit

// One mask word: a set mask bit blocks its source, and suspend blocks the whole word.
module efi_mask_gate (
  input  wire logic [7:0] events_i,
  input  wire logic [7:0] mask_i,
  input  wire logic       suspend_i,
  output logic [7:0]      live_o
);
  import efi_pkg::*;

  assign live_o = suspend_i ? BYTE_ZERO : (events_i & ~mask_i);

endmodule : efi_mask_gate

// [testbench/efi_host_model.sv]
`timescale 1ns/1ps
module efi_host_model (
  input  wire logic          ref_clk_i,
  output efi_pkg::efi_bus_s  bus_o
);
  import efi_pkg::*;
  initial bus_o = '0;
  // Released lines show the inverse so that stale address or data use is exposed.
  task automatic cyc(input logic r, input logic [2:0] p, input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) #1;
    bus_o = '{rd: r, wr: !r, page: p, addr: a, wdata: d};
    @(posedge ref_clk_i) #1;
    bus_o = '{rd: 1'b0, wr: 1'b0, page: ~p, addr: ~a, wdata: ~d};
  endtask : cyc
endmodule : efi_host_model

// [testbench/efi_assertions.sv]
`timescale 1ns/1ps
module efi_assertions (
  input wire logic                    ref_clk_i,
  input wire logic                    reset_i,
  input wire logic                    soft_reset_i,
  input wire efi_pkg::efi_port_mode_e port_mode_i,
  input wire efi_pkg::efi_bus_s       bus_i,
  input wire efi_pkg::efi_events_s    events_i,
  input wire logic [7:0]              rdata_o,
  input wire logic [7:0]              vector_bits_o,
  input wire logic                    irq_o,
  input wire logic                    irq_oe_n_o
);
  import efi_pkg::*;
  logic [7:0] ctl_reg;
  wire rd_v = bus_i.rd && bus_i.page == PAGE_STAT && bus_i.addr == ADDR_VECTOR && !soft_reset_i;
  wire wr_c = bus_i.wr && bus_i.page == PAGE_CTRL && bus_i.addr == ADDR_CTRL && !soft_reset_i;
  // A shadow of the control word is needed to tell a toggle from a rewrite.
  always_ff @(posedge ref_clk_i or posedge reset_i)
    if (reset_i) ctl_reg <= CTRL_RESET;
    else if (soft_reset_i) ctl_reg <= CTRL_RESET;
    else if (wr_c) ctl_reg <= bus_i.wdata;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  irq_drive_a: assert property (irq_o == 1'b0)
    else $error("request drive not low");
  irq_vec_a: assert property (irq_oe_n_o == (vector_bits_o == 8'h00))
    else $error("request mismatch");
  rd_data_a: assert property (rd_v |=> rdata_o == $past(vector_bits_o))
    else $error("bad read data");
  rd_clear_a: assert property (rd_v && port_mode_i != EFI_PORT_STREAM && events_i == '0
    |=> vector_bits_o == 8'h00 && irq_oe_n_o) else $error("read did not clear");
  stream_keep_a: assert property (rd_v && port_mode_i == EFI_PORT_STREAM
    |=> (~vector_bits_o & $past(vector_bits_o)) == 8'h00) else $error("stream read cleared");
  ack_clear_a: assert property (wr_c && bus_i.wdata[CTRL_ACK_BIT] != ctl_reg[CTRL_ACK_BIT]
    && events_i == '0 |=> vector_bits_o == 8'h00) else $error("toggle did not clear");
  hold_susp_a: assert property (ctl_reg[CTRL_SUSPEND_BIT] && !soft_reset_i
    |=> (vector_bits_o & ~$past(vector_bits_o)) == 8'h00) else $error("event while suspended");
  rdata_idle_a: assert property (!bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data stuck");
  soft_clear_a: assert property (soft_reset_i |=> vector_bits_o == 8'h00 ##0 irq_oe_n_o)
    else $error("soft reset");
  cover property (rd_v ##1 vector_bits_o == 8'h00);
  cover property (ctl_reg[CTRL_SUSPEND_BIT]);
  cover property (!irq_oe_n_o);
endmodule : efi_assertions
bind efi_interrupt_unit efi_assertions i_chk (.ref_clk_i, .reset_i, .soft_reset_i, .port_mode_i,
  .bus_i, .events_i, .rdata_o, .vector_bits_o, .irq_o, .irq_oe_n_o);

// [testbench/test_efi_interrupt_unit.sv]
`timescale 1ns/1ps
module test_efi_interrupt_unit;
  import efi_pkg::*;
  logic           ref_clk_i = 1'b0, reset_i = 1'b1, soft_reset_i = 1'b0;
  efi_port_mode_e port_mode_i = EFI_PORT_PROCESSOR;
  efi_events_s    events_i = '0;
  efi_bus_s       bus_i;
  logic [7:0]     rdata_o, vector_bits_o;
  logic           irq_o, irq_oe_n_o;
  int             num_errors = 0, num_checks = 0;
  // One hex digit per event position gives its category; F marks an unassigned bit.
  localparam logic [127:0] CAT_MAP = 128'h7777_3111_4434_446F_5555_55F0_7666_6542;
  efi_interrupt_unit i_dut (.ref_clk_i, .reset_i, .soft_reset_i, .port_mode_i, .bus_i,
    .events_i, .rdata_o, .vector_bits_o, .irq_o, .irq_oe_n_o);
  efi_host_model i_host (.ref_clk_i, .bus_o(bus_i));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_host.cyc(1'b0, PAGE_CTRL, a, d);
  endtask : wr
  task automatic rd(input logic [2:0] p, input logic [4:0] a, input logic [7:0] e);
    i_host.cyc(1'b1, p, a, 8'h00);
    chk(rdata_o, e);
  endtask : rd
  task automatic pulse(input efi_events_s e);
    @(posedge ref_clk_i) #1 events_i = e;
    @(posedge ref_clk_i) #1 events_i = '0;
  endtask : pulse
  task automatic t_reset();
    rd(PAGE_CTRL, ADDR_MASK0, 8'h00);
    for (int a = 1; a < 4; a++) rd(PAGE_CTRL, 5'(ADDR_MASK0 + a), 8'hFF);
    rd(PAGE_STAT, 5'h13, 8'h00);
    pulse(32'hFFFF_FF00);
    chk(vector_bits_o, 8'h00);
  endtask : t_reset
  task automatic t_cat();
    logic [3:0] c;
    logic [7:0] e;
    for (int a = 0; a < 4; a++) wr(5'(ADDR_MASK0 + a), 8'h00);
    for (int i = 0; i < 32; i++) begin
      c = CAT_MAP[i*4 +: 4];
      e = c[3] ? 8'h00 : 8'h01 << c;
      pulse(32'h1 << i);
      chk(vector_bits_o, e);
      chk({7'h00, irq_oe_n_o}, {7'h00, c[3]});
      rd(PAGE_STAT, ADDR_VECTOR, e);
      chk(vector_bits_o, 8'h00);
    end
  endtask : t_cat
  task automatic t_susp();
    wr(ADDR_MASK0, 8'h01);
    pulse(32'h3);
    chk(vector_bits_o, 8'h10);
    wr(ADDR_CTRL, 8'h40);
    pulse(32'h80);
    rd(PAGE_CTRL, ADDR_MASK0, 8'h01);
    rd(PAGE_STAT, ADDR_VECTOR, 8'h10);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MASK0, 8'h00);
  endtask : t_susp
  task automatic t_ack();
    port_mode_i = EFI_PORT_STREAM;
    pulse(32'h1);
    rd(PAGE_STAT, ADDR_VECTOR, 8'h04);
    chk(vector_bits_o, 8'h04);
    wr(ADDR_CTRL, 8'h20);
    chk(vector_bits_o, 8'h00);
  endtask : t_ack
  task automatic t_soft();
    pulse(32'h1);
    chk(vector_bits_o, 8'h04);
    @(posedge ref_clk_i) #1 soft_reset_i = 1'b1;
    @(posedge ref_clk_i) #1 soft_reset_i = 1'b0;
    chk(vector_bits_o, 8'h00);
    rd(PAGE_CTRL, ADDR_MASK1, 8'hFF);
  endtask : t_soft
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    t_reset();
    t_cat();
    t_susp();
    t_ack();
    t_soft();
    conclude();
  end
endmodule : test_efi_interrupt_unit
